// *** clamp_offset_channel.sv ***
// one converter channel: offset servo during the clamp window, held offset otherwise
`timescale 1ns/1ns
module clamp_offset_channel (
    // clock and control
    input wire logic clock,
    input wire logic rst,
    input wire logic enable,
    // clamp window
    input wire logic clampActive,
    input wire logic midscale,
    // samples
    input wire logic [7:0] sampleIn,
    output logic [7:0] codeOut
);
    logic signed [9:0] offset;
    logic signed [9:0] next_offset;
    logic [7:0] next_codeOut;
    logic signed [11:0] sum;
    logic [7:0] corrected;
    logic [7:0] target;

    always_comb begin
        sum = $signed({4'h0, sampleIn}) + 12'(offset);
        if (sum < 0) begin
            corrected = 8'h00;
        end else if (sum > $signed({4'h0, video_clamp_pkg::CODE_MAX})) begin
            corrected = video_clamp_pkg::CODE_MAX;
        end else begin
            corrected = sum[7:0];
        end
        target = midscale ? video_clamp_pkg::MIDSCALE_CODE : video_clamp_pkg::GROUND_CODE;
        next_offset = offset;
        // one step per pixel: slow, but never overshoots on a noisy back porch
        if (clampActive) begin
            if (corrected > target && offset > -10'sd255) begin
                next_offset = offset - 10'sd1;
            end else if (corrected < target && offset < 10'sd255) begin
                next_offset = offset + 10'sd1;
            end
        end
        // outside the window the offset simply stays where the clamp left it
        next_codeOut = corrected;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            offset <= 10'sd0;
            codeOut <= 8'h00;
        end else if (enable) begin
            offset <= next_offset;
            codeOut <= next_codeOut;
        end
    end
endmodule : clamp_offset_channel

// *** hsync_source.sv ***
// horizontal sync source standing in for the graphics or video source
`timescale 1ns/1ns
module hsync_source (
    // clock
    input wire logic clock,
    // sync pin
    output logic hsyncPin
);
    logic activeLevel = 1'b1;
    initial hsyncPin = 1'b0;
    task automatic idle(input logic level);
        @(posedge clock);
        #1 activeLevel = level;
        hsyncPin = ~level;
    endtask : idle
    // any width: the clamp must count from the trailing edge only
    task automatic pulse(input int width);
        @(posedge clock);
        #1 hsyncPin = activeLevel;
        repeat (width) @(posedge clock);
        #1 hsyncPin = ~activeLevel;
    endtask : pulse
endmodule : hsync_source

// *** tb_video_clamp_timing.sv ***
// self-checking bench: registers, clamp window timing, per-channel offset servo
`timescale 1ns/1ns
module tb_video_clamp_timing;
    logic clock, rst, enable, regWrite, regRead, clampActive;
    logic [7:0] regAddr, regWriteData, regReadData;
    logic [7:0] samp [3];
    logic [7:0] code [3];
    logic hsyncPin;
    int err_total, comparisons, curL, n;
    int offs [3];
    logic [7:0] dTab [5] = '{8'h08, 8'h26, 8'h05, 8'h00, 8'h10};
    logic [7:0] lTab [5] = '{8'h14, 8'h03, 8'h0a, 8'h01, 8'h00};
    logic [7:0] d, l;
    logic [2:0] sel;
    video_clamp_timing video_clamp_timing_inst (.clock(clock), .rst(rst), .enable(enable),
        .hsyncPin(hsyncPin), .regAddr(regAddr), .regWrite(regWrite),
        .regWriteData(regWriteData), .regRead(regRead), .regReadData(regReadData),
        .sampleRed(samp[0]), .sampleGreen(samp[1]), .sampleBlue(samp[2]),
        .codeRed(code[0]), .codeGreen(code[1]), .codeBlue(code[2]),
        .clampActive(clampActive));
    hsync_source hsync_source_inst (.clock(clock), .hsyncPin(hsyncPin));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock);
        #1 {regAddr, regWriteData, regWrite} = {addr, data, 1'b1};
        @(posedge clock);
        #1 regWrite = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] addr, input logic [7:0] want);
        @(posedge clock);
        #1 {regAddr, regRead} = {addr, 1'b1};
        @(posedge clock);
        #1 regRead = 1'b0;
        check(regReadData, want);
    endtask : rd
    function automatic int sat(input int x);
        return x < 0 ? 0 : (x > 255 ? 255 : x);
    endfunction : sat
    // model: one offset step toward the target per clamped pixel
    task automatic servo(input int steps);
        int tgt;
        repeat (steps) for (int c = 0; c < 3; c++) begin
            tgt = sel[2 - c] ? 128 : 0;
            if (sat(int'(samp[c]) + offs[c]) > tgt && offs[c] > -255) offs[c]--;
            else if (sat(int'(samp[c]) + offs[c]) < tgt && offs[c] < 255) offs[c]++;
        end
    endtask : servo
    initial begin
        rst = 1'b1;
        enable = 1'b1;
        {regWrite, regRead, regAddr, regWriteData} = 18'h00000;
        samp = '{default: 8'h00};
        offs = '{default: 0};
        void'($urandom(41));
        repeat (8) @(posedge clock);
        #1 rst = 1'b0;
        rd(8'h19, 8'h08);
        rd(8'h1a, 8'h14);
        rd(8'h1b, 8'h00);
        rd(8'h1c, 8'h01);
        rd(8'h3f, 8'h00);
        // a write while the clock enable is low must leave the register untouched
        enable = 1'b0;
        wr(8'h19, 8'hff);
        enable = 1'b1;
        rd(8'h19, 8'h08);
        $display("test register reset done");
        curL = 20;
        sel = 3'h0;
        for (int i = 0; i < 5; i++) begin
            if (i == 2 || i == 3) begin
                // the pin moving to the new idle level after a polarity flip forms a trailing edge, hence one extra window
                wr(8'h1c, {7'h00, i != 2});
                // the pin sits at its old idle level, which the new polarity reads as active
                rd(8'h1d, 8'h02);
                hsync_source_inst.idle(i != 2);
                servo(curL);
                repeat (100) @(posedge clock);
            end
            d = (i == 2) ? 8'($urandom_range(15)) : dTab[i];
            l = (i == 2) ? 8'($urandom_range(30, 1)) : lTab[i];
            sel = 3'($urandom);
            wr(8'h19, d);
            wr(8'h1a, l);
            wr(8'h1b, {sel, 5'h1f});
            rd(8'h1b, {sel, 5'h00});
            for (int c = 0; c < 3; c++) samp[c] = 8'($urandom_range(40) + (sel[2 - c] ? 108 : 0));
            hsync_source_inst.pulse(3 + i * 20);
            n = 0;
            repeat (60) begin
                @(posedge clock);
                #1 n++;
                if (clampActive === 1'b1) break;
            end
            check(8'(n), (l == 8'h00) ? 8'h3c : d + 8'h04);
            n = 0;
            while (clampActive === 1'b1 && n < 300) begin
                @(posedge clock);
                #1 n++;
            end
            check(8'(n), l);
            servo(l);
            curL = l;
            repeat (4) @(posedge clock);
            #1;
            for (int c = 0; c < 3; c++) begin
                check(code[c], 8'(sat(int'(samp[c]) + offs[c])));
            end
            for (int c = 0; c < 3; c++) samp[c] = 8'($urandom);
            repeat (3) @(posedge clock);
            #1;
            for (int c = 0; c < 3; c++) begin
                check(code[c], 8'(sat(int'(samp[c]) + offs[c])));
            end
            $display("test window %0d done", i);
        end
        // a trailing edge inside a running window cuts it and starts a full new one
        d = 8'h02;
        l = 8'h14;
        wr(8'h19, d);
        wr(8'h1a, l);
        hsync_source_inst.pulse(2);
        repeat (8) @(posedge clock);
        #1 check(8'(clampActive), 8'h01);
        hsync_source_inst.pulse(2);
        n = 0;
        while (clampActive === 1'b1 && n < 60) begin
            @(posedge clock);
            #1 n++;
        end
        check(8'(n), 8'h03);
        n = 0;
        while (clampActive !== 1'b1 && n < 60) begin
            @(posedge clock);
            #1 n++;
        end
        check(8'(n), d + 8'h01);
        n = 0;
        while (clampActive === 1'b1 && n < 300) begin
            @(posedge clock);
            #1 n++;
        end
        check(8'(n), l);
        $display("test restart done");
        close_out();
    end
    // the tests need well under a thousand cycles; this allows thirty thousand
    initial begin
        #300000;
        err_total++;
        close_out();
    end
endmodule : tb_video_clamp_timing

// *** video_clamp_pkg.sv ***
// constants shared by the clamp timing generator and its per-channel offset loops
package video_clamp_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CLAMP_START_DELAY = 8'h19;
    localparam logic [7:0] ADDR_CLAMP_LENGTH = 8'h1a;
    localparam logic [7:0] ADDR_CLAMP_LEVEL_SELECT = 8'h1b;
    localparam logic [7:0] ADDR_SYNC_CONTROL = 8'h1c;
    localparam logic [7:0] ADDR_CLAMP_STATUS = 8'h1d;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int LEVEL_SELECT_LSB = 5;
    localparam int SYNC_POLARITY_BIT = 0;
    localparam int STATUS_CLAMP_BIT = 0;
    localparam int STATUS_SYNC_BIT = 1;

    // ------------------------------------------------------------
    // reset values and widths
    // ------------------------------------------------------------
    localparam int CHANNELS = 3;
    localparam int CODE_WIDTH = 8;
    localparam int OFFSET_WIDTH = 10;
    localparam logic [7:0] RESET_START_DELAY = 8'h08;
    localparam logic [7:0] RESET_LENGTH = 8'h14;
    localparam logic [2:0] RESET_LEVEL_SELECT = 3'h0;
    localparam logic RESET_SYNC_POLARITY = 1'b1;

    // ------------------------------------------------------------
    // clamp targets and code ceiling
    // ------------------------------------------------------------
    localparam logic [7:0] GROUND_CODE = 8'h00;
    localparam logic [7:0] MIDSCALE_CODE = 8'h80;
    localparam logic [7:0] CODE_MAX = 8'hff;

    typedef enum logic [1:0] {
        WAIT_EDGE = 2'b00,
        COUNT_DELAY = 2'b01,
        CLAMPING = 2'b10
    } clamp_state_type;
endpackage : video_clamp_pkg

// *** video_clamp_timing.sv ***
// clamp timing generator: hsync trailing edge to clamp window, registers, three channels
`timescale 1ns/1ns
module video_clamp_timing (
    // clock and control
    input wire logic clock,
    input wire logic rst,
    input wire logic enable,
    // sync pin
    input wire logic hsyncPin,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWriteData,
    input wire logic regRead,
    output logic [7:0] regReadData,
    // converter samples and corrected codes
    input wire logic [7:0] sampleRed,
    input wire logic [7:0] sampleGreen,
    input wire logic [7:0] sampleBlue,
    output logic [7:0] codeRed,
    output logic [7:0] codeGreen,
    output logic [7:0] codeBlue,
    // clamp window
    output logic clampActive
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] clampStartDelay;
    logic [7:0] clampLength;
    logic [2:0] clampLevelSelect;
    logic syncPolarity;
    logic [7:0] next_clampStartDelay;
    logic [7:0] next_clampLength;
    logic [2:0] next_clampLevelSelect;
    logic next_syncPolarity;
    logic [7:0] next_regReadData;

    // ------------------------------------------------------------
    // sync input
    // ------------------------------------------------------------
    logic hsyncMeta;
    logic hsyncSync;
    logic syncActivePrev;
    logic syncActive;
    logic trailingEdge;

    // ------------------------------------------------------------
    // window state
    // ------------------------------------------------------------
    video_clamp_pkg::clamp_state_type state;
    video_clamp_pkg::clamp_state_type next_state;
    logic [7:0] count;
    logic [7:0] next_count;
    logic next_clampActive;

    always_comb begin
        next_clampStartDelay = clampStartDelay;
        next_clampLength = clampLength;
        next_clampLevelSelect = clampLevelSelect;
        next_syncPolarity = syncPolarity;
        next_regReadData = regReadData;
        if (regWrite) begin
            case (regAddr)
                video_clamp_pkg::ADDR_CLAMP_START_DELAY: begin
                    next_clampStartDelay = regWriteData;
                end
                video_clamp_pkg::ADDR_CLAMP_LENGTH: begin
                    next_clampLength = regWriteData;
                end
                video_clamp_pkg::ADDR_CLAMP_LEVEL_SELECT: begin
                    next_clampLevelSelect =
                        regWriteData[video_clamp_pkg::LEVEL_SELECT_LSB +: 3];
                end
                video_clamp_pkg::ADDR_SYNC_CONTROL: begin
                    next_syncPolarity = regWriteData[video_clamp_pkg::SYNC_POLARITY_BIT];
                end
                default: begin
                end
            endcase
        end
        if (regRead) begin
            case (regAddr)
                video_clamp_pkg::ADDR_CLAMP_START_DELAY: begin
                    next_regReadData = clampStartDelay;
                end
                video_clamp_pkg::ADDR_CLAMP_LENGTH: begin
                    next_regReadData = clampLength;
                end
                video_clamp_pkg::ADDR_CLAMP_LEVEL_SELECT: begin
                    next_regReadData = 8'h00;
                    next_regReadData[video_clamp_pkg::LEVEL_SELECT_LSB +: 3] = clampLevelSelect;
                end
                video_clamp_pkg::ADDR_SYNC_CONTROL: begin
                    next_regReadData = 8'h00;
                    next_regReadData[video_clamp_pkg::SYNC_POLARITY_BIT] = syncPolarity;
                end
                video_clamp_pkg::ADDR_CLAMP_STATUS: begin
                    next_regReadData = 8'h00;
                    next_regReadData[video_clamp_pkg::STATUS_CLAMP_BIT] = clampActive;
                    next_regReadData[video_clamp_pkg::STATUS_SYNC_BIT] = syncActive;
                end
                default: begin
                    next_regReadData = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            clampStartDelay <= video_clamp_pkg::RESET_START_DELAY;
            clampLength <= video_clamp_pkg::RESET_LENGTH;
            clampLevelSelect <= video_clamp_pkg::RESET_LEVEL_SELECT;
            syncPolarity <= video_clamp_pkg::RESET_SYNC_POLARITY;
            regReadData <= 8'h00;
        end else if (enable) begin
            clampStartDelay <= next_clampStartDelay;
            clampLength <= next_clampLength;
            clampLevelSelect <= next_clampLevelSelect;
            syncPolarity <= next_syncPolarity;
            regReadData <= next_regReadData;
        end
    end

    // ------------------------------------------------------------
    // sync synchroniser and trailing edge
    // ------------------------------------------------------------
    // the polarity is applied after the second flop so the first one feeds nothing else
    assign syncActive = syncPolarity ? hsyncSync : ~hsyncSync;
    assign trailingEdge = syncActivePrev & ~syncActive;

    always_ff @(posedge clock) begin
        if (rst) begin
            hsyncMeta <= 1'b0;
            hsyncSync <= 1'b0;
            syncActivePrev <= 1'b0;
        end else if (enable) begin
            hsyncMeta <= hsyncPin;
            hsyncSync <= hsyncMeta;
            syncActivePrev <= syncActive;
        end
    end

    // ------------------------------------------------------------
    // window sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_count = count;
        if (trailingEdge) begin
            // a new edge aborts any window still running, so one window per line
            next_state = video_clamp_pkg::COUNT_DELAY;
            next_count = clampStartDelay;
        end else begin
            case (state)
                video_clamp_pkg::WAIT_EDGE: begin
                    next_count = 8'h00;
                end
                video_clamp_pkg::COUNT_DELAY: begin
                    if (count == 8'h00) begin
                        next_count = clampLength;
                        next_state = (clampLength == 8'h00) ? video_clamp_pkg::WAIT_EDGE
                                                            : video_clamp_pkg::CLAMPING;
                    end else begin
                        next_count = count - 8'h01;
                    end
                end
                video_clamp_pkg::CLAMPING: begin
                    if (count == 8'h01) begin
                        next_state = video_clamp_pkg::WAIT_EDGE;
                        next_count = 8'h00;
                    end else begin
                        next_count = count - 8'h01;
                    end
                end
                default: begin
                    next_state = video_clamp_pkg::WAIT_EDGE;
                    next_count = 8'h00;
                end
            endcase
        end
        next_clampActive = (next_state == video_clamp_pkg::CLAMPING);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= video_clamp_pkg::WAIT_EDGE;
            count <= 8'h00;
            clampActive <= 1'b0;
        end else if (enable) begin
            state <= next_state;
            count <= next_count;
            clampActive <= next_clampActive;
        end
    end

    // ------------------------------------------------------------
    // per-channel offset loops
    // ------------------------------------------------------------
    logic [7:0] samples [video_clamp_pkg::CHANNELS];
    logic [7:0] codes [video_clamp_pkg::CHANNELS];

    assign samples[0] = sampleRed;
    assign samples[1] = sampleGreen;
    assign samples[2] = sampleBlue;
    assign codeRed = codes[0];
    assign codeGreen = codes[1];
    assign codeBlue = codes[2];

    // bit 7 selects red, bit 6 green, bit 5 blue
    for (genvar ch = 0; ch < video_clamp_pkg::CHANNELS; ch++) begin : gen_channel
        clamp_offset_channel channel (
            .clock(clock),
            .rst(rst),
            .enable(enable),
            .clampActive(clampActive),
            .midscale(clampLevelSelect[2 - ch]),
            .sampleIn(samples[ch]),
            .codeOut(codes[ch])
        );
    end
endmodule : video_clamp_timing

// *** video_clamp_timing_checker.sv ***
// checker: clamp window timing, register readback and held offset
`timescale 1ns/1ns
module video_clamp_timing_checker (
    // clock and control
    input wire logic clock,
    input wire logic rst,
    input wire logic enable,
    // sync pin and register port
    input wire logic hsyncPin,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWriteData,
    input wire logic regRead,
    input wire logic [7:0] regReadData,
    // one channel and the window
    input wire logic [7:0] sampleRed,
    input wire logic [7:0] codeRed,
    input wire logic clampActive
);
    logic [7:0] dly, len, dcnt, lcnt;
    logic [2:0] sel;
    logic pol, m, y, prevAct, cnting, expOn;
    wire act = pol ? y : ~y;
    wire edgeE = prevAct & ~act;
    // shadow of the window generator, fed only from the pins
    always_ff @(posedge clock) begin
        if (rst) begin
            dly <= 8'h08;
            len <= 8'h14;
            sel <= 3'h0;
            pol <= 1'b1;
            {m, y, prevAct, cnting, expOn} <= 5'h00;
            dcnt <= 8'h00;
            lcnt <= 8'h00;
        end else if (enable) begin
            m <= hsyncPin;
            y <= m;
            prevAct <= act;
            if (regWrite && regAddr == 8'h19) dly <= regWriteData;
            if (regWrite && regAddr == 8'h1a) len <= regWriteData;
            if (regWrite && regAddr == 8'h1b) sel <= regWriteData[7:5];
            if (regWrite && regAddr == 8'h1c) pol <= regWriteData[0];
            if (edgeE) begin
                cnting <= 1'b1;
                dcnt <= dly;
                expOn <= 1'b0;
            end else if (cnting && dcnt != 8'h00) begin
                dcnt <= dcnt - 8'h01;
            end else if (cnting) begin
                cnting <= 1'b0;
                expOn <= (len != 8'h00);
                lcnt <= len - 8'h01;
            end else if (expOn && lcnt == 8'h00) begin
                expOn <= 1'b0;
            end else if (expOn) begin
                lcnt <= lcnt - 8'h01;
            end
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // three quiet cycles so a late offset step has surely reached the code
    sequence quiet_seq;
        (!clampActive && $stable(sampleRed))[*3];
    endsequence
    AST_WINDOW_START: assert property ($rose(expOn) |-> clampActive)
        else $error("clamp window did not open on time");
    AST_WINDOW_HOLD: assert property (expOn && $past(expOn) |-> clampActive)
        else $error("clamp window closed early");
    // a restart with zero delay may legally reopen the window one cycle after the cut
    AST_WINDOW_CLOSE: assert property (
        $fell(expOn) |-> !clampActive ##1 (!clampActive || expOn))
        else $error("clamp window ran long");
    AST_ZERO_LEN: assert property (edgeE && len == 8'h00 |-> ##2 !clampActive[*8])
        else $error("window opened with zero length");
    AST_READ_DELAY: assert property (
        regRead && regAddr == 8'h19 |=> regReadData == $past(dly))
        else $error("start delay readback wrong");
    AST_READ_SELECT: assert property (
        regRead && regAddr == 8'h1b |=> regReadData == {$past(sel), 5'h00})
        else $error("level select readback wrong");
    AST_READ_POLARITY: assert property (
        regRead && regAddr == 8'h1c |=> regReadData == {7'h00, $past(pol)})
        else $error("polarity readback wrong");
    AST_READ_STATUS: assert property (
        regRead && regAddr == 8'h1d |=> regReadData == {6'h00, $past(act), $past(clampActive)})
        else $error("status readback wrong");
    AST_HOLD_OFFSET: assert property (quiet_seq |=> $stable(codeRed))
        else $error("code moved outside the clamp window");
endmodule : video_clamp_timing_checker
bind video_clamp_timing video_clamp_timing_checker video_clamp_timing_checker_inst (
    .clock(clock), .rst(rst), .enable(enable), .hsyncPin(hsyncPin), .regAddr(regAddr),
    .regWrite(regWrite), .regWriteData(regWriteData), .regRead(regRead),
    .regReadData(regReadData), .sampleRed(sampleRed), .codeRed(codeRed),
    .clampActive(clampActive));
